// File: rtl/pdti_pkg.sv
// package: constants and carrier types of the host task interpreter
package pdti_pkg;

   // ==========================================================
   // task codes, four ASCII characters packed big-endian
   // ==========================================================
   localparam logic [31:0] PDTI_TASK_WARM   = 32'h47616964; // warm restart
   localparam logic [31:0] PDTI_TASK_COLD   = 32'h47414944; // cold restart
   localparam logic [31:0] PDTI_TASK_SINK   = 32'h5357536b; // become_sink_task
   localparam logic [31:0] PDTI_TASK_SOURCE = 32'h53575372; // become_source_task
   localparam logic [31:0] PDTI_TASK_DFP    = 32'h53574446; // become_downstream_task
   localparam logic [31:0] PDTI_TASK_UFP    = 32'h53575546; // become_upstream_task
   localparam logic [31:0] PDTI_CMD_IDLE    = 32'h00000000;
   localparam logic [31:0] PDTI_CMD_RESET   = 32'h00000000;
   localparam logic [63:0] PDTI_DATA_RESET  = 64'h0000000000000000;

   // ==========================================================
   // result_code_field encodings and positions
   // ==========================================================
   localparam logic [3:0] PDTI_RES_SUCCESS = 4'h0;
   localparam logic [3:0] PDTI_RES_TIMEOUT = 4'h1;
   localparam logic [3:0] PDTI_RES_REJECT  = 4'h3;
   localparam logic [3:0] PDTI_RES_RXLOCK  = 4'h4;
   localparam int         PDTI_RES_LSB     = 0;
   localparam int         PDTI_INFO_LSB    = 4;

   // ==========================================================
   // timing: error recovery delay before restart
   // ==========================================================
   localparam int          PDTI_CLK_HZ        = 100_000_000;
   localparam int          PDTI_RECOVERY_MS   = 1000;
   localparam longint      PDTI_RECOVERY_CYC  =
      longint'(PDTI_RECOVERY_MS) * longint'(PDTI_CLK_HZ) / 1000;
   localparam logic [27:0] PDTI_RECOVERY_DFLT = 28'(PDTI_RECOVERY_CYC);

   // ==========================================================
   // carrier types
   // ==========================================================
   // request to the policy engine
   typedef struct packed {
      logic valid;     // one-cycle start pulse
      logic power;     // 1 power-role swap, 0 data-role swap
      logic to_source; // power target source (else sink)
      logic to_dfp;    // data target dfp (else ufp)
   } pdti_swap_req_t;

   // answer from the policy engine
   typedef struct packed {
      logic done;      // one-cycle completion pulse
      logic accepted;  // partner sent accept
      logic rejected;  // reject or not supported
      logic waiting;   // partner answered wait
      logic failed;    // accepted swap failed
   } pdti_swap_rsp_t;

   // partner / own role view
   typedef struct packed {
      logic is_source;
      logic is_dfp;
      logic partner_drp;
      logic partner_drd;
      logic altmode_active;
   } pdti_role_t;

endpackage : pdti_pkg

// File: rtl/pdti_recovery_timer.sv
// file: error recovery delay counter used before a restart
`timescale 1ns/10ps
`default_nettype none
module pdti_recovery_timer
   import pdti_pkg::*;
#(
   parameter logic [27:0] CYCLES = PDTI_RECOVERY_DFLT
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   input  wire logic start_i,
   output logic      expired_o
);
   typedef struct packed {
      logic [27:0] cnt;
      logic        run;
      logic        exp;
   } pdti_tmr_st_t;

   pdti_tmr_st_t st_ff;
   pdti_tmr_st_t nxt_st;

   // ==========================================================
   // counter: expired pulses once CYCLES after start
   // ==========================================================
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.exp = 1'b0;
      if (start_i) begin
         nxt_st.run = 1'b1;
         nxt_st.cnt = 28'h0000001;
      end else if (st_ff.run) begin
         if (st_ff.cnt >= CYCLES) begin
            nxt_st.run = 1'b0;
            nxt_st.exp = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 28'h0000001;
         end
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   assign expired_o = st_ff.exp;
endmodule : pdti_recovery_timer
`default_nettype wire

// File: rtl/pdti_task_interp.sv
// file: four-character task interpreter for restart and role swap tasks
//
// Summary of operation
// - output bytes are written to data register before command clears.
// - data register untouched while command register reads zero.
// - result low nibble: 0 ok, 1 timeout, 3 reject, 4 rx locked.
// - upper nibble only carries info on success; the code always writes it as zero.
// - warm restart: error recovery, one second wait, warm reboot.
// - after restart all command and data registers read zero.
// - cold restart: error recovery, one second wait, bootloader reboot.
// - become sink rejected without partner dual role or on refusal.
// - become source rejected without partner dual role or on refusal.
// - success when already in role or swap completes normally.
// - task keeps running while partner answers wait.
// - become downstream exits alternate modes before the data swap.
// - become upstream exits modes first; rejected without data swap support.
// - failed accepted swap triggers resets; success updates role registers.
`timescale 1ns/10ps
`default_nettype none
module pdti_task_interp
   import pdti_pkg::*;
#(
   parameter logic [27:0] RECOVERY_CYCLES = PDTI_RECOVERY_DFLT
) (
   input  wire logic           sys_clk_i,
   input  wire logic           rst_n_i,
   input  wire logic           ce_i,
   // host side of the command / data registers
   input  wire logic           cmd_wr_i,
   input  wire logic [31:0]    cmd_wdata_i,
   input  wire logic           data_wr_i,
   input  wire logic [63:0]    data_wdata_i,
   output logic      [31:0]    task_command_reg_o,
   output logic      [63:0]    task_data_reg_o,
   // role view and policy engine
   input  wire pdti_role_t     role_i,
   input  wire logic           rx_locked_i,
   output pdti_swap_req_t      swap_req_o,
   input  wire pdti_swap_rsp_t swap_rsp_i,
   output logic                altmode_exit_o,
   input  wire logic           altmode_exit_done_i,
   output logic                soft_reset_o,
   output logic                hard_reset_o,
   output logic                role_update_o,
   output logic                recovery_o,
   output logic                warm_restart_o,
   output logic                cold_restart_o
);

   // ==========================================================
   // state machine and state record
   // ==========================================================
   typedef enum logic [6:0] {
      ST_IDLE   = 7'b0000001,
      ST_DEC    = 7'b0000010,
      ST_EXIT   = 7'b0000100,
      ST_SWAP   = 7'b0001000,
      ST_RESULT = 7'b0010000,
      ST_DONE   = 7'b0100000,
      ST_RECOV  = 7'b1000000
   } pdti_state_t;

   typedef struct packed {
      pdti_state_t    fsm;
      logic [31:0]    cmd;
      logic [63:0]    data;
      logic [3:0]     res;
      logic           cold;
      logic           power;
      logic           to_src;
      logic           to_dfp;
      pdti_swap_req_t req;
      logic           exit_req;
      logic           soft_rst;
      logic           hard_rst;
      logic           role_upd;
      logic           recov;
      logic           warm_go;
      logic           cold_go;
   } pdti_st_t;

   pdti_st_t st_ff;
   pdti_st_t nxt_st;
   logic     tmr_start;
   logic     tmr_expired;

   // one second error recovery wait lives in the helper
   pdti_recovery_timer #(
      .CYCLES    (RECOVERY_CYCLES)
   ) u_recovery (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .start_i   (tmr_start),
      .expired_o (tmr_expired)
   );

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.req       = '0;
      nxt_st.exit_req  = 1'b0;
      nxt_st.soft_rst  = 1'b0;
      nxt_st.hard_rst  = 1'b0;
      nxt_st.role_upd  = 1'b0;
      nxt_st.warm_go   = 1'b0;
      nxt_st.cold_go   = 1'b0;
      tmr_start        = 1'b0;
      // device leaves idle data alone
      // host writes land only while idle; a busy task owns the registers
      if (st_ff.fsm == ST_IDLE && data_wr_i) begin
         nxt_st.data = data_wdata_i;
      end
      case (st_ff.fsm)
         ST_IDLE: begin
            if (cmd_wr_i && cmd_wdata_i != PDTI_CMD_IDLE) begin
               nxt_st.cmd = cmd_wdata_i;
               nxt_st.fsm = ST_DEC;
            end
         end
         ST_DEC: begin
            nxt_st.fsm = ST_RESULT;
            nxt_st.res = PDTI_RES_REJECT; // unknown codes are refused
            case (st_ff.cmd)
               PDTI_TASK_WARM, PDTI_TASK_COLD: begin
                  nxt_st.cold  = (st_ff.cmd == PDTI_TASK_COLD);
                  nxt_st.recov = 1'b1;
                  tmr_start    = 1'b1;
                  nxt_st.fsm   = ST_RECOV;
               end
               PDTI_TASK_SINK, PDTI_TASK_SOURCE: begin
                  nxt_st.power  = 1'b1;
                  nxt_st.to_src = (st_ff.cmd == PDTI_TASK_SOURCE);
                  if (role_i.is_source == nxt_st.to_src) begin
                     nxt_st.res = PDTI_RES_SUCCESS;
                  end else if (!role_i.partner_drp) begin
                     nxt_st.res = PDTI_RES_REJECT;
                  end else begin
                     nxt_st.req = '{valid: 1'b1, power: 1'b1,
                                    to_source: nxt_st.to_src, to_dfp: 1'b0};
                     nxt_st.fsm = ST_SWAP;
                  end
               end
               PDTI_TASK_DFP, PDTI_TASK_UFP: begin
                  nxt_st.power  = 1'b0;
                  nxt_st.to_dfp = (st_ff.cmd == PDTI_TASK_DFP);
                  if (role_i.is_dfp == nxt_st.to_dfp) begin
                     nxt_st.res = PDTI_RES_SUCCESS;
                  end else if (!role_i.partner_drd) begin
                     nxt_st.res = PDTI_RES_REJECT;
                  end else if (role_i.altmode_active) begin
                     nxt_st.exit_req = 1'b1;
                     nxt_st.fsm      = ST_EXIT;
                  end else begin
                     nxt_st.req = '{valid: 1'b1, power: 1'b0,
                                    to_source: 1'b0, to_dfp: nxt_st.to_dfp};
                     nxt_st.fsm = ST_SWAP;
                  end
               end
               default: begin
                  nxt_st.res = PDTI_RES_REJECT;
               end
            endcase
         end
         ST_EXIT: begin
            if (altmode_exit_done_i) begin
               nxt_st.req = '{valid: 1'b1, power: 1'b0,
                              to_source: 1'b0, to_dfp: st_ff.to_dfp};
               nxt_st.fsm = ST_SWAP;
            end
         end
         ST_SWAP: begin
            if (swap_rsp_i.done && !swap_rsp_i.waiting) begin
               nxt_st.fsm = ST_RESULT;
               if (rx_locked_i) begin
                  nxt_st.res = PDTI_RES_RXLOCK;
               end else if (swap_rsp_i.rejected || !swap_rsp_i.accepted) begin
                  nxt_st.res = PDTI_RES_REJECT;
               end else if (swap_rsp_i.failed) begin
                  nxt_st.res      = PDTI_RES_TIMEOUT;
                  nxt_st.soft_rst = 1'b1;
                  nxt_st.hard_rst = 1'b1;
               end else begin
                  nxt_st.res      = PDTI_RES_SUCCESS;
                  nxt_st.role_upd = 1'b1;
               end
            end
         end
         ST_RESULT: begin
            nxt_st.data      = PDTI_DATA_RESET;
            nxt_st.data[7:0] = {4'h0, st_ff.res};
            nxt_st.fsm       = ST_DONE;
         end
         ST_DONE: begin
            nxt_st.cmd = PDTI_CMD_IDLE;
            nxt_st.fsm = ST_IDLE;
         end
         ST_RECOV: begin
            if (tmr_expired) begin
               nxt_st.warm_go = !st_ff.cold;
               nxt_st.cold_go = st_ff.cold;
               nxt_st.recov   = 1'b0;
               nxt_st.cmd     = PDTI_CMD_RESET;
               nxt_st.data    = PDTI_DATA_RESET;
               nxt_st.fsm     = ST_IDLE;
            end
         end
         default: begin
            nxt_st.fsm = ST_IDLE;
         end
      endcase
   end

   // state register; ce low freezes everything
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff     <= '0;
         st_ff.fsm <= ST_IDLE;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops
   // ==========================================================
   assign task_command_reg_o = st_ff.cmd;
   assign task_data_reg_o    = st_ff.data;
   assign swap_req_o         = st_ff.req;
   assign altmode_exit_o     = st_ff.exit_req;
   assign soft_reset_o       = st_ff.soft_rst;
   assign hard_reset_o       = st_ff.hard_rst;
   assign role_update_o      = st_ff.role_upd;
   assign recovery_o         = st_ff.recov;
   assign warm_restart_o     = st_ff.warm_go;
   assign cold_restart_o     = st_ff.cold_go;

   // ==========================================================
   // assertions
   // ==========================================================
   property p_data_before_clear;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && st_ff.fsm == ST_DONE) |=> (task_command_reg_o == 32'h0)
         && (task_data_reg_o[3:0] == $past(st_ff.res));
   endproperty
   a_data_before_clear: assert property (p_data_before_clear)
      else $error("command cleared without result loaded");

   property p_data_stable_idle;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_ff.fsm == ST_IDLE && !data_wr_i && !cmd_wr_i && ce_i)
         |=> $stable(task_data_reg_o);
   endproperty
   a_data_stable_idle: assert property (p_data_stable_idle)
      else $error("data register changed while idle");

   property p_result_legal;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_ff.fsm == ST_DONE) |-> (task_data_reg_o[3:0] inside {4'h0, 4'h1, 4'h3, 4'h4});
   endproperty
   a_result_legal: assert property (p_result_legal)
      else $error("illegal result code");

   property p_upper_nibble;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_ff.fsm == ST_DONE && task_data_reg_o[3:0] != 4'h0)
         |-> (task_data_reg_o[7:4] == 4'h0);
   endproperty
   a_upper_nibble: assert property (p_upper_nibble)
      else $error("info nibble set on failure");

   property p_restart_clears;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && st_ff.fsm == ST_RECOV && tmr_expired)
         |=> (task_command_reg_o == 32'h0 && task_data_reg_o == 64'h0
              && (warm_restart_o || cold_restart_o));
   endproperty
   a_restart_clears: assert property (p_restart_clears)
      else $error("restart left registers nonzero");

   property p_already_role;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && st_ff.fsm == ST_DEC && st_ff.cmd == PDTI_TASK_SINK && !role_i.is_source)
         |=> (st_ff.fsm == ST_RESULT && st_ff.res == 4'h0);
   endproperty
   a_already_role: assert property (p_already_role)
      else $error("already-in-role swap not successful");

   property p_wait_runs;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && st_ff.fsm == ST_SWAP && swap_rsp_i.waiting) |=> (st_ff.fsm == ST_SWAP);
   endproperty
   a_wait_runs: assert property (p_wait_runs)
      else $error("swap ended during wait");

   property p_exit_before_swap;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_ff.fsm == ST_EXIT) |-> !swap_req_o.valid;
   endproperty
   a_exit_before_swap: assert property (p_exit_before_swap)
      else $error("data swap sent before mode exit");

   property p_fail_resets;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (soft_reset_o) |-> (st_ff.fsm == ST_RESULT && st_ff.res == 4'h1);
   endproperty
   a_fail_resets: assert property (p_fail_resets)
      else $error("reset without timeout result");

   c_swap_ok: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      role_update_o);
   c_swap_fail: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hard_reset_o);
   c_exit_path: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      st_ff.fsm == ST_EXIT ##1 st_ff.fsm == ST_SWAP);
   c_restart: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      warm_restart_o || cold_restart_o);

endmodule : pdti_task_interp
`default_nettype wire

// File: test/pdti_pe_model.sv
// policy engine and alternate mode stand-in facing the task interpreter
`timescale 1ns/10ps
`default_nettype none
module pdti_pe_model
   import pdti_pkg::*;
(
   input  wire logic           sys_clk_i,
   input  wire logic           rst_n_i,
   input  wire pdti_swap_req_t swap_req_i,
   output pdti_swap_rsp_t      swap_rsp_o,
   input  wire logic           altmode_exit_i,
   output logic                altmode_exit_done_o,
   input  wire logic [1:0]     mode_i,   // 0 accept, 1 reject, 2 fail after accept
   input  wire logic [3:0]     waits_i   // wait answers sent before the final one
);
   int waits_left;

   // ==========================================================
   // swap answers
   // ==========================================================
   // one answer in flight only: the interpreter never overlaps swaps
   initial begin
      swap_rsp_o = '0;
      forever begin
         @(posedge sys_clk_i iff (rst_n_i && swap_req_i.valid));
         waits_left = int'(waits_i);
         while (waits_left > 0) begin
            repeat (4) @(posedge sys_clk_i);
            #1 swap_rsp_o = '{done: 1'b1, waiting: 1'b1, default: 1'b0};
            @(posedge sys_clk_i);
            #1 swap_rsp_o = '0;
            waits_left--;
         end
         repeat (4) @(posedge sys_clk_i);
         #1 swap_rsp_o = '{done: 1'b1, accepted: (mode_i != 2'd1),
                           rejected: (mode_i == 2'd1), waiting: 1'b0,
                           failed: (mode_i == 2'd2)};
         @(posedge sys_clk_i);
         #1 swap_rsp_o = '0;
      end
   end

   // ==========================================================
   // alternate mode exit, slow on purpose so ordering shows
   // ==========================================================
   initial begin
      altmode_exit_done_o = 1'b0;
      forever begin
         @(posedge sys_clk_i iff (rst_n_i && altmode_exit_i));
         repeat (6) @(posedge sys_clk_i);
         #1 altmode_exit_done_o = 1'b1;
         @(posedge sys_clk_i);
         #1 altmode_exit_done_o = 1'b0;
      end
   end
endmodule : pdti_pe_model
`default_nettype wire

// File: test/pdti_task_interp_tb.sv
// self-checking bench for the host task interpreter
`timescale 1ns/10ps
`default_nettype none
module pdti_task_interp_tb import pdti_pkg::*;;
   localparam logic [27:0] RC  = 28'd20;   // short recovery wait for simulation
   localparam int          RCI = 20;

   logic sys_clk_i, rst_n_i, ce_i, cmd_wr_i, data_wr_i, rx_locked_i, done_pulse;
   logic [31:0] cmd_wdata_i, task_command_reg_o;
   logic [63:0] data_wdata_i, task_data_reg_o;
   logic altmode_exit_o, soft_reset_o, hard_reset_o, role_update_o;
   logic recovery_o, warm_restart_o, cold_restart_o;
   logic [1:0] pe_mode;
   logic [3:0] pe_waits;
   pdti_role_t     role_i;
   pdti_swap_req_t swap_req_o, last_req;
   pdti_swap_rsp_t swap_rsp_i;
   int num_errors, tests_run, cnt, t_alt, t_req, n_req, n_soft, n_hard, n_upd, n_warm, n_cold;

   pdti_task_interp #(.RECOVERY_CYCLES(RC)) dut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .cmd_wr_i(cmd_wr_i), .cmd_wdata_i(cmd_wdata_i), .data_wr_i(data_wr_i),
      .data_wdata_i(data_wdata_i), .task_command_reg_o(task_command_reg_o),
      .task_data_reg_o(task_data_reg_o), .role_i(role_i), .rx_locked_i(rx_locked_i),
      .swap_req_o(swap_req_o), .swap_rsp_i(swap_rsp_i), .altmode_exit_o(altmode_exit_o),
      .altmode_exit_done_i(done_pulse), .soft_reset_o(soft_reset_o),
      .hard_reset_o(hard_reset_o), .role_update_o(role_update_o), .recovery_o(recovery_o),
      .warm_restart_o(warm_restart_o), .cold_restart_o(cold_restart_o));

   pdti_pe_model pe (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .swap_req_i(swap_req_o),
      .swap_rsp_o(swap_rsp_i), .altmode_exit_i(altmode_exit_o),
      .altmode_exit_done_o(done_pulse), .mode_i(pe_mode), .waits_i(pe_waits));

   // ==========================================================
   // clock and pulse monitor
   // ==========================================================
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // pulses are one cycle wide, so count them instead of polling
   always @(posedge sys_clk_i) begin
      cnt++;
      if (swap_req_o.valid === 1'b1) begin
         n_req++;
         t_req = cnt;
         last_req = swap_req_o;
      end
      if (altmode_exit_o === 1'b1) t_alt = cnt;
      if (soft_reset_o === 1'b1) n_soft++;
      if (hard_reset_o === 1'b1) n_hard++;
      if (role_update_o === 1'b1) n_upd++;
      if (warm_restart_o === 1'b1) n_warm++;
      if (cold_restart_o === 1'b1) n_cold++;
   end

   // ==========================================================
   // host side helpers
   // ==========================================================
   task automatic cyc;
      @(posedge sys_clk_i);
      #1;
   endtask : cyc

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic write_data(input logic [63:0] d);
      data_wr_i = 1'b1;
      data_wdata_i = d;
      cyc();
      data_wr_i = 1'b0;
   endtask : write_data

   task automatic write_cmd(input logic [31:0] code);
      cmd_wr_i = 1'b1;
      cmd_wdata_i = code;
      cyc();
      cmd_wr_i = 1'b0;
   endtask : write_cmd

   // poll for completion like a host would, with a bound
   task automatic poll_done(output int el);
      el = 1;
      while (task_command_reg_o !== 32'h0 && el < 400) begin
         cyc();
         el++;
      end
      chk("completion", 64'h1, 64'(el < 400));
   endtask : poll_done

   task automatic swap_check(input logic [31:0] code, input logic [3:0] res, input int reqs);
      int el, r0;
      r0 = n_req;
      write_data(64'hfedc_ba98_7654_3210);   // preload must be replaced by the result
      write_cmd(code);
      chk("cmd_busy", 64'h1, 64'(task_command_reg_o != 32'h0));
      poll_done(el);
      chk("result", {60'h0, res}, task_data_reg_o);
      chk("std_result", 64'h1, 64'(task_data_reg_o[3:0] < 4'h5));
      chk("swap_requests", 64'(reqs), 64'(n_req - r0));
   endtask : swap_check

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic test_in_role;
      role_i = '{is_source: 1'b1, is_dfp: 1'b1, default: 1'b0};
      swap_check(PDTI_TASK_SOURCE, PDTI_RES_SUCCESS, 0);
      swap_check(PDTI_TASK_DFP, PDTI_RES_SUCCESS, 0);
      role_i = '0;
      swap_check(PDTI_TASK_SINK, PDTI_RES_SUCCESS, 0);
      swap_check(PDTI_TASK_UFP, PDTI_RES_SUCCESS, 0);
      $display("test_in_role done");
   endtask : test_in_role

   task automatic test_no_dual_role;
      role_i = '{is_source: 1'b1, is_dfp: 1'b1, default: 1'b0};
      swap_check(PDTI_TASK_SINK, PDTI_RES_REJECT, 0);
      swap_check(PDTI_TASK_UFP, PDTI_RES_REJECT, 0);
      role_i = '0;
      swap_check(PDTI_TASK_SOURCE, PDTI_RES_REJECT, 0);
      swap_check(32'h4142_4344, PDTI_RES_REJECT, 0);
      $display("test_no_dual_role done");
   endtask : test_no_dual_role

   task automatic test_outcomes;
      logic [3:0] exp_res [3];
      int u0, s0, h0;
      exp_res = '{PDTI_RES_SUCCESS, PDTI_RES_REJECT, PDTI_RES_TIMEOUT};
      role_i = '{is_source: 1'b1, partner_drp: 1'b1, default: 1'b0};
      for (int m = 0; m < 3; m++) begin
         pe_mode = 2'(m);
         u0 = n_upd;
         s0 = n_soft;
         h0 = n_hard;
         swap_check(PDTI_TASK_SINK, exp_res[m], 1);
         chk("req_kind", 64'h4, 64'(last_req[2:0]));
         chk("role_update", 64'(m == 0), 64'(n_upd - u0));
         chk("soft_reset", 64'(m == 2), 64'(n_soft - s0));
         chk("hard_reset", 64'(m == 2), 64'(n_hard - h0));
      end
      pe_mode = 2'd0;
      rx_locked_i = 1'b1;
      swap_check(PDTI_TASK_SINK, PDTI_RES_RXLOCK, 1);
      rx_locked_i = 1'b0;
      $display("test_outcomes done");
   endtask : test_outcomes

   task automatic test_wait_and_hold;
      int el;
      logic [63:0] kept;
      role_i = '{partner_drp: 1'b1, default: 1'b0};
      pe_waits = 4'd3;
      write_cmd(PDTI_TASK_SOURCE);
      cyc();
      write_data(64'h5555_aaaa_5555_aaaa);  // host breaks order: must be ignored
      poll_done(el);
      chk("wait_kept_running", 64'h1, 64'(el >= 18));
      chk("result", 64'h0, task_data_reg_o);
      kept = task_data_reg_o;
      pe_waits = 4'd0;
      ce_i = 1'b0;
      write_data(64'h0f0f_0f0f_0f0f_0f0f);  // frozen clock enable: must not land
      ce_i = 1'b1;
      repeat (10) cyc();
      chk("data_held", kept, task_data_reg_o);
      $display("test_wait_and_hold done");
   endtask : test_wait_and_hold

   task automatic test_altmode;
      role_i = '{partner_drd: 1'b1, altmode_active: 1'b1, default: 1'b0};
      swap_check(PDTI_TASK_DFP, PDTI_RES_SUCCESS, 1);
      chk("exit_before_swap", 64'h1, 64'(t_req - t_alt >= 7));
      chk("req_dfp", 64'h1, 64'(last_req.to_dfp && !last_req.power));
      role_i = '{is_dfp: 1'b1, partner_drd: 1'b1, altmode_active: 1'b1, default: 1'b0};
      pe_mode = 2'd1;
      swap_check(PDTI_TASK_UFP, PDTI_RES_REJECT, 1);
      chk("exit_before_swap", 64'h1, 64'(t_req - t_alt >= 7));
      pe_mode = 2'd0;
      $display("test_altmode done");
   endtask : test_altmode

   task automatic test_restart(input logic [31:0] code, input bit warm);
      int el, w0, c0;
      w0 = n_warm;
      c0 = n_cold;
      write_data(64'h0123_4567_89ab_cdef);
      write_cmd(code);
      repeat (2) cyc();
      chk("recovery", 64'h1, 64'(recovery_o));
      el = 2;
      while (n_warm == w0 && n_cold == c0 && el < RCI + 20) begin
         cyc();
         el++;
      end
      chk("restart_delay", 64'h1, 64'(el >= RCI && el <= RCI + 6));
      chk("warm_pulse", 64'(warm), 64'(n_warm - w0));
      chk("cold_pulse", 64'(!warm), 64'(n_cold - c0));
      cyc();
      chk("cmd_cleared", 64'h0, 64'(task_command_reg_o));
      chk("data_cleared", 64'h0, task_data_reg_o);
      $display("test_restart done");
   endtask : test_restart

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // ==========================================================
   // main sequence and watchdog
   // ==========================================================
   initial begin
      rst_n_i = 1'b0;
      {ce_i, cmd_wr_i, data_wr_i, rx_locked_i} = 4'h8;
      cmd_wdata_i = 32'h0;
      data_wdata_i = 64'h0;
      role_i = '0;
      pe_mode = 2'd0;
      pe_waits = 4'd0;
      repeat (4) @(posedge sys_clk_i);
      #1 rst_n_i = 1'b1;
      chk("cmd_reset", 64'h0, 64'(task_command_reg_o));
      chk("data_reset", 64'h0, task_data_reg_o);
      test_in_role();
      test_no_dual_role();
      test_outcomes();
      test_wait_and_hold();
      test_altmode();
      test_restart(PDTI_TASK_WARM, 1'b1);
      test_restart(PDTI_TASK_COLD, 1'b0);
      final_report();
   end

   // whole run is a few hundred cycles; the 10000-cycle limit allows dozens of times that
   initial begin
      #100000;
      num_errors++;
      $display("[ERR] watchdog expected finish seen hang");
      final_report();
   end
endmodule : pdti_task_interp_tb
`default_nettype wire
